// >>> core/rmi_core.sv
// receive message indication sequencer: serialises each message with a defined type code onto strobe, code and data byte
// assumes msg_valid pulses one cycle per received message; msg_ready low asks the source to hold
`timescale 1ns/100ps

module rmi_core (
  input wire logic ref_clk,
  input wire logic rst,
  input wire rmi_pkg::rmi_msg_type msg_in,
  input wire logic msg_valid,
  output logic msg_ready,
  output rmi_pkg::rmi_ind_type ind
);

  typedef enum logic [1:0] {ST_IDLE, ST_SEND, ST_GAP} rmi_state_type;

  rmi_state_type state_r, state_nxt;
  rmi_pkg::rmi_msg_type msg_r, msg_nxt;
  logic [3:0] idx_r, idx_nxt;
  logic [3:0] len_r, len_nxt;
  logic [3:0] gap_r, gap_nxt;
  logic strobe_r, strobe_nxt;
  logic [7:0] data_r, data_nxt;
  logic [3:0] sel_idx;
  logic [7:0] sel_byte;

  // strobe lengths
  // strobe length per type code; reserved codes produce no indication
  function automatic logic [3:0] strobe_len(input logic [4:0] c, input logic d);
    if (c <= rmi_pkg::CODE_PM_LAST || c == rmi_pkg::CODE_UNLOCK) begin
      strobe_len = rmi_pkg::LEN_BASIC;
    end else if (c == rmi_pkg::CODE_SLOT_PWR || c == rmi_pkg::CODE_LTR) begin
      strobe_len = rmi_pkg::LEN_SIX;
    end else if (c == rmi_pkg::CODE_OBFF) begin
      strobe_len = rmi_pkg::LEN_OBFF;
    end else if (c == rmi_pkg::CODE_VDM0 || c == rmi_pkg::CODE_VDM1) begin
      strobe_len = d ? rmi_pkg::LEN_VDM_DATA : rmi_pkg::LEN_VDM_NODATA;
    end else if (c <= rmi_pkg::CODE_ATS_LAST) begin
      strobe_len = rmi_pkg::LEN_BASIC;
    end else begin
      strobe_len = 4'h0;
    end
  endfunction

  // byte for the cycle about to be driven
  assign sel_idx = (state_r == ST_SEND) ? idx_r + 4'h1 : 4'h0;

  rmi_byte_sel u_sel (
    .msg(state_r == ST_SEND ? msg_r : msg_in),
    .idx(sel_idx),
    .byte_out(sel_byte)
  );

  // accept only when idle; the gap cycle refuses, so the source holds its message
  assign msg_ready = (state_r == ST_IDLE);

  // sequencer next state
  always_comb begin
    state_nxt = state_r;
    msg_nxt = msg_r;
    idx_nxt = idx_r;
    len_nxt = len_r;
    gap_nxt = gap_r;
    strobe_nxt = 1'b0;
    data_nxt = data_r;
    case (state_r)
      ST_IDLE: begin
        if (msg_valid && strobe_len(msg_in.code, msg_in.has_data) != 4'h0) begin
          state_nxt = ST_SEND;
          msg_nxt = msg_in;
          len_nxt = strobe_len(msg_in.code, msg_in.has_data);
          idx_nxt = 4'h0;
          strobe_nxt = 1'b1;
          data_nxt = sel_byte;
        end
      end
      ST_SEND: begin
        // counts on without any user input
        if (idx_r + 4'h1 >= len_r) begin
          state_nxt = ST_GAP;
          gap_nxt = rmi_pkg::LEN_GAP;
          data_nxt = 8'h00;
        end else begin
          idx_nxt = idx_r + 4'h1;
          strobe_nxt = 1'b1;
          data_nxt = sel_byte;
        end
      end
      ST_GAP: begin
        if (gap_r <= 4'h1) begin
          state_nxt = ST_IDLE;
        end else begin
          gap_nxt = gap_r - 4'h1;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // sequencer registers
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_r <= ST_IDLE;
      msg_r <= '0;
      idx_r <= 4'h0;
      len_r <= 4'h0;
      gap_r <= 4'h0;
      strobe_r <= 1'b0;
      data_r <= 8'h00;
    end else begin
      state_r <= state_nxt;
      msg_r <= msg_nxt;
      idx_r <= idx_nxt;
      len_r <= len_nxt;
      gap_r <= gap_nxt;
      strobe_r <= strobe_nxt;
      data_r <= data_nxt;
    end
  end

  // code taken from the held message, stable per strobe
  // one packed assignment keeps a single driver on the port
  assign ind = '{strobe: strobe_r, code: msg_r.code, data: data_r};

  // strobe run length check helper; run_r equals the full length on the edge the strobe falls
  logic [3:0] run_r, run_nxt;
  always_comb begin
    run_nxt = strobe_r ? run_r + 4'h1 : 4'h0;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      run_r <= 4'h0;
    end else begin
      run_r <= run_nxt;
    end
  end

  chk_basic_len: assert property (@(posedge ref_clk) disable iff (rst)
    ($fell(strobe_r) && ($past(msg_r.code) <= rmi_pkg::CODE_PM_LAST
    || $past(msg_r.code) == rmi_pkg::CODE_UNLOCK
    || ($past(msg_r.code) > rmi_pkg::CODE_VDM1 && $past(msg_r.code) <= rmi_pkg::CODE_ATS_LAST)))
    |-> run_r == rmi_pkg::LEN_BASIC)
    else $error("basic message strobe not two cycles");
  chk_slot_len: assert property (@(posedge ref_clk) disable iff (rst)
    ($fell(strobe_r) && $past(msg_r.code) == rmi_pkg::CODE_SLOT_PWR) |-> run_r == rmi_pkg::LEN_SIX)
    else $error("slot power strobe not six cycles");
  chk_ltr_bytes: assert property (@(posedge ref_clk) disable iff (rst)
    ($rose(strobe_r) && msg_r.code == rmi_pkg::CODE_LTR) |-> ##2 data_r == msg_r.payload[7:0]
    ##1 data_r == msg_r.payload[15:8] ##1 data_r == msg_r.payload[23:16] ##1 data_r == msg_r.payload[31:24])
    else $error("ltr byte order wrong");
  chk_obff_len: assert property (@(posedge ref_clk) disable iff (rst)
    ($rose(strobe_r) && msg_r.code == rmi_pkg::CODE_OBFF) |-> strobe_r[*3] ##1 !strobe_r)
    else $error("obff strobe not three cycles");
  chk_vdm_len: assert property (@(posedge ref_clk) disable iff (rst)
    ($fell(strobe_r) && ($past(msg_r.code) == rmi_pkg::CODE_VDM0 || $past(msg_r.code) == rmi_pkg::CODE_VDM1))
    |-> run_r == ($past(msg_r.has_data) ? rmi_pkg::LEN_VDM_DATA : rmi_pkg::LEN_VDM_NODATA))
    else $error("vendor strobe length wrong");
  chk_vdm_bytes: assert property (@(posedge ref_clk) disable iff (rst)
    ($rose(strobe_r) && msg_r.code == rmi_pkg::CODE_VDM0) |-> data_r == msg_r.req_id[15:8]
    ##1 data_r == msg_r.req_id[7:0] ##1 data_r == msg_r.vendor_id[7:0] ##1 data_r == msg_r.vendor_id[15:8])
    else $error("vendor byte order wrong");
  chk_gap_idle: assert property (@(posedge ref_clk) disable iff (rst)
    (strobe_r && run_r + 4'h1 == len_r) |=> !strobe_r)
    else $error("no idle cycle between strobes");
  chk_no_stall: assert property (@(posedge ref_clk) disable iff (rst)
    strobe_r |-> ##[1:8] !strobe_r)
    else $error("strobe ran too long");
  chk_code_stable: assert property (@(posedge ref_clk) disable iff (rst)
    (strobe_r && $past(strobe_r)) |-> $stable(ind.code))
    else $error("type code changed within strobe");
  chk_reserved_drop: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(strobe_r) |-> msg_r.code <= rmi_pkg::CODE_ATS_LAST)
    else $error("reserved code indicated");

endmodule

// >>> core/rmi_pkg.sv
// package for the receive message indication block: type codes, strobe lengths, carriers
// assumes one 125 MHz clock and a synchronous active-high reset
package rmi_pkg;

  localparam int TYPE_W = 5;
  localparam int BYTE_W = 8;
  localparam int LEN_W = 4;

  // message type codes on the indication port
  localparam logic [4:0] CODE_ERR_LAST = 5'h02;
  localparam logic [4:0] CODE_INT_LAST = 5'h0a;
  localparam logic [4:0] CODE_PM_LAST = 5'h0e;
  localparam logic [4:0] CODE_SLOT_PWR = 5'h0f;
  localparam logic [4:0] CODE_LTR = 5'h10;
  localparam logic [4:0] CODE_OBFF = 5'h11;
  localparam logic [4:0] CODE_UNLOCK = 5'h12;
  localparam logic [4:0] CODE_VDM0 = 5'h13;
  localparam logic [4:0] CODE_VDM1 = 5'h14;
  localparam logic [4:0] CODE_ATS_LAST = 5'h18;

  // strobe and gap lengths in cycles
  localparam logic [3:0] LEN_BASIC = 4'h2;
  localparam logic [3:0] LEN_OBFF = 4'h3;
  localparam logic [3:0] LEN_VDM_NODATA = 4'h4;
  localparam logic [3:0] LEN_SIX = 4'h6;
  localparam logic [3:0] LEN_VDM_DATA = 4'h8;
  localparam logic [3:0] LEN_GAP = 4'h1;

  // one received message as handed over by the link side
  typedef struct packed {
    logic [4:0] code;
    logic [15:0] req_id;    // bus in [15:8], device/function in [7:0]
    logic [15:0] vendor_id;
    logic [31:0] payload;   // slot power dword, or snoop [15:0] / no-snoop [31:16], or obff code [7:0]
    logic has_data;
  } rmi_msg_type;

  // indication port as seen by user logic
  typedef struct packed {
    logic strobe;
    logic [4:0] code;
    logic [7:0] data;
  } rmi_ind_type;

endpackage

// >>> core/rmi_byte_sel.sv
// byte selector: picks the parameter byte for a given message and cycle index
// assumes the message fields stay stable while the index steps
`timescale 1ns/100ps
module rmi_byte_sel (
  input wire rmi_pkg::rmi_msg_type msg,
  input wire logic [3:0] idx,
  output logic [7:0] byte_out
);

  function automatic logic is_vdm(input logic [4:0] c);
    is_vdm = (c == rmi_pkg::CODE_VDM0) || (c == rmi_pkg::CODE_VDM1);
  endfunction

  // sequence decode per message kind
  always_comb begin
    byte_out = 8'h00;
    case (idx)
      4'h0: byte_out = msg.req_id[15:8];
      4'h1: byte_out = msg.req_id[7:0];
      // vendor id low, high, then payload bytes
      4'h2: byte_out = is_vdm(msg.code) ? msg.vendor_id[7:0] : msg.payload[7:0];
      4'h3: byte_out = is_vdm(msg.code) ? msg.vendor_id[15:8] : msg.payload[15:8];
      4'h4: byte_out = is_vdm(msg.code) ? msg.payload[7:0] : msg.payload[23:16];
      4'h5: byte_out = is_vdm(msg.code) ? msg.payload[15:8] : msg.payload[31:24];
      4'h6: byte_out = msg.payload[23:16];
      4'h7: byte_out = msg.payload[31:24];
      default: byte_out = 8'h00;
    endcase
  end

endmodule

// >>> tb/rmi_user_model.sv
// user-side model: takes every indication byte and records the last strobe
// assumes ind is registered on ref_clk and never waits for this side
`timescale 1ns/100ps
module rmi_user_model (
  input wire logic ref_clk,
  input wire logic rst,
  input wire rmi_pkg::rmi_ind_type ind,
  output logic [3:0] seen_len,
  output logic [7:0] seen_byte [0:7],
  output logic [4:0] seen_code,
  output logic [3:0] seen_gap,
  output logic code_bad
);
  logic [3:0] idle_cnt;
  // no completion space claimed
  // this side issues no non-posted requests, so no completion can be outstanding
  // never stalls
  // no ready output exists, so every strobe cycle is captured here
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      seen_len <= 4'h0;
      seen_gap <= 4'h0;
      idle_cnt <= 4'h1;
      code_bad <= 1'b0;
    end else if (ind.strobe) begin
      idle_cnt <= 4'h0;
      seen_byte[idle_cnt != 4'h0 ? 4'h0 : seen_len] <= ind.data;
      seen_len <= idle_cnt != 4'h0 ? 4'h1 : seen_len + 4'h1;
      if (idle_cnt != 4'h0) begin
        seen_code <= ind.code;
        seen_gap <= idle_cnt;
      end else if (ind.code !== seen_code) begin
        code_bad <= 1'b1;
      end
    end else if (idle_cnt != 4'hf) begin
      idle_cnt <= idle_cnt + 4'h1; // saturates, only zero matters
    end
  end
endmodule

// >>> tb/testbench.sv
// bench for the message indication sequencer: every code once, reserved codes dropped
// assumes the link side may present one message whenever msg_ready is high
`timescale 1ns/100ps
module testbench;
  localparam logic [15:0] REQ = 16'h3cc3;
  localparam logic [15:0] VEN = 16'h5a96;
  localparam logic [31:0] PAY = 32'h1122_3344;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic msg_valid = 1'b0;
  rmi_pkg::rmi_msg_type msg_in = '0;
  logic msg_ready;
  rmi_pkg::rmi_ind_type ind;
  logic [3:0] seen_len;
  logic [7:0] seen_byte [0:7];
  logic [4:0] seen_code;
  logic [3:0] seen_gap;
  logic code_bad;
  int mismatches = 0;
  int check_count = 0;
  int cycles = 0;

  rmi_core dut_u (.ref_clk(ref_clk), .rst(rst), .msg_in(msg_in), .msg_valid(msg_valid),
    .msg_ready(msg_ready), .ind(ind));
  rmi_user_model user_u (.ref_clk(ref_clk), .rst(rst), .ind(ind), .seen_len(seen_len),
    .seen_byte(seen_byte), .seen_code(seen_code), .seen_gap(seen_gap), .code_bad(code_bad));

  // free-running clock, 8 ns period
  initial begin
    forever #4 ref_clk = ~ref_clk;
  end

  // hang guard: the whole run needs well under a thousand cycles
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      mismatches = mismatches + 1;
      complete_run();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count = check_count + 1;
    if (seen !== exp) begin
      mismatches = mismatches + 1;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic logic [3:0] exp_len(input logic [4:0] c, input logic d);
    if (c == 5'h0f || c == 5'h10) return 4'h6;
    if (c == 5'h11) return 4'h3;
    if (c == 5'h13 || c == 5'h14) return d ? 4'h8 : 4'h4;
    return 4'h2;
  endfunction

  function automatic logic [7:0] exp_byte(input logic [4:0] c, input int i);
    logic [63:0] s;
    s = {16'h0000, PAY, REQ[7:0], REQ[15:8]};
    if (c == 5'h13 || c == 5'h14) s = {PAY, VEN, REQ[7:0], REQ[15:8]};
    return s[i*8 +: 8];
  endfunction

  // one message: wait for ready, pulse valid, then wait until ready returns
  task automatic send(input logic [4:0] c, input logic d);
    int n;
    n = 0;
    msg_in = '{code: c, req_id: REQ, vendor_id: VEN, payload: PAY, has_data: d};
    while (msg_ready !== 1'b1 && n < 40) begin
      @(negedge ref_clk);
      n = n + 1;
    end
    msg_valid = 1'b1;
    @(negedge ref_clk);
    msg_valid = 1'b0;
    while (msg_ready !== 1'b1 && n < 40) begin
      check(msg_ready, 1'b0); // held off while busy
      @(negedge ref_clk);
      n = n + 1;
    end
    check(n < 40, 1'b1); // indication completes
  endtask

  task automatic test_all_codes();
    for (int c = 0; c < 25; c++) begin
      send(c[4:0], c[0]);
      check(seen_code, c); // code on the port
      check(seen_len, exp_len(c[4:0], c[0])); // strobe length
      for (int i = 0; i < exp_len(c[4:0], c[0]); i++) begin
        check(seen_byte[i], exp_byte(c[4:0], i)); // byte order
      end
      check(seen_gap != 4'h0, 1'b1); // idle gap
    end
    check(code_bad, 1'b0); // code stable
    $display("test_all_codes done");
  endtask

  // vendor messages with the data flag the other way round from test_all_codes
  task automatic test_vdm_swap();
    for (int c = 19; c < 21; c++) begin
      send(c[4:0], ~c[0]);
      check(seen_code, c); // code on the port
      check(seen_len, exp_len(c[4:0], ~c[0])); // strobe length
      for (int i = 0; i < exp_len(c[4:0], ~c[0]); i++) begin
        check(seen_byte[i], exp_byte(c[4:0], i)); // byte order
      end
    end
    $display("test_vdm_swap done");
  endtask

  // reset cuts a slot power strobe; the port must come back idle and take the next message
  task automatic test_mid_reset();
    msg_in = '{code: 5'h0f, req_id: REQ, vendor_id: VEN, payload: PAY, has_data: 1'b0};
    msg_valid = 1'b1;
    @(negedge ref_clk);
    msg_valid = 1'b0;
    @(negedge ref_clk);
    check(ind.strobe, 1'b1); // strobe under way
    rst = 1'b1;
    repeat (2) @(negedge ref_clk);
    rst = 1'b0;
    check(ind.strobe, 1'b0); // strobe idle after reset
    check(msg_ready, 1'b1); // port free after reset
    send(5'h00, 1'b0);
    check(seen_len, 4'h2); // strobe length
    check(seen_byte[0], REQ[15:8]); // bus number
    check(seen_byte[1], REQ[7:0]); // device function
    $display("test_mid_reset done");
  endtask

  // reserved codes are swallowed without a strobe
  task automatic test_reserved();
    for (int c = 25; c < 32; c++) begin
      send(c[4:0], 1'b0);
      for (int k = 0; k < 3; k++) begin
        @(negedge ref_clk);
        check(ind.strobe, 1'b0); // reserved codes
      end
    end
    $display("test_reserved done");
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (16) @(negedge ref_clk);
    rst = 1'b0;
    @(negedge ref_clk);
    test_all_codes();
    test_vdm_swap();
    test_reserved();
    test_mid_reset();
    complete_run();
  end
endmodule
